/* File: src/pwm_ramp_pkg.sv */
package pwm_ramp_pkg;

  // ----------------------------------------------------------------
  // Characteristic handles
  // ----------------------------------------------------------------
  localparam logic [7:0] HANDLE_STARTUP_MODE = 8'h4d;
  localparam logic [7:0] HANDLE_DUTY_WORD = 8'h50;
  localparam logic [7:0] HANDLE_PERIOD_TICKS = 8'h53;
  localparam logic [7:0] HANDLE_RAMP_TIME = 8'h56;

  // ----------------------------------------------------------------
  // Reset and factory values
  // ----------------------------------------------------------------
  localparam logic [7:0] STARTUP_MODE_RESET = 8'h01;
  localparam logic [31:0] DUTY_WORD_RESET = 32'hffffffff;
  localparam logic [15:0] PERIOD_TICKS_RESET = 16'h8235;
  localparam logic [15:0] RAMP_TIME_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Startup modes and duty levels
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_START_LOW = 8'h00;
  localparam logic [7:0] MODE_START_HIGH = 8'h01;
  localparam logic [7:0] MODE_KEEP_CURRENT = 8'h02;
  localparam logic [7:0] DUTY_FULL = 8'hff;
  localparam logic [7:0] DUTY_NONE = 8'h00;
  localparam logic [31:0] DUTY_ALL_HIGH = 32'hffffffff;
  localparam logic [31:0] DUTY_ALL_LOW = 32'h00000000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int TICK_PS = 250000;
  localparam logic [17:0] TICK_PS_W = 18'd250000;
  localparam logic [17:0] CLK_PERIOD_PS_W = 18'd8000;
  localparam longint RAMP_UNIT_MS = 100;
  localparam int DUTY_STEPS = 255;
  // Clock cycles between single duty steps for one ramp unit
  localparam longint RAMP_STEP_CYCLES =
    (RAMP_UNIT_MS * 64'd1000000000 / longint'(CLK_PERIOD_PS)) / longint'(DUTY_STEPS);

  typedef enum logic [0:0] {
    PH_LOAD = 1'b0,
    PH_RUN = 1'b1
  } phase_t;

endpackage

/* File: src/quad_pwm_with_ramp.sv */
`timescale 1ns/1ps
// Contract
// - Mode 0 starts all channels fully low and allows sleep.
// - Mode 1 starts all channels fully high and allows sleep.
// - Writing mode 2 saves current duty for next power-on; blocks sleep.
// - Startup mode is one byte, factory 1, kept across power loss.
// - Duty word has four bytes; top byte is channel one.
// - Duty byte X gives high time of X/255 of the period.
// - Reading duty word returns the last written value.
// - Duty word reads all ones after power-on.
// - Sleep is allowed only while the duty word is all ones.
// - Period word in 0.25 us ticks is shared by all channels.
// - Period defaults to 0x8235, reads back, kept across power loss.
// - Shared ramp time reads and writes, defaults to zero meaning instant.
// - One ramp unit is 100 ms; larger means slower moves.
module quad_pwm_with_ramp #(
  parameter longint STEP_CYCLES = pwm_ramp_pkg::RAMP_STEP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic attr_wr,
  input wire logic attr_rd,
  input wire logic [7:0] attr_handle,
  input wire logic [31:0] attr_wdata,
  output logic [31:0] attr_rdata,
  output logic attr_rvalid,
  input wire logic nv_valid,
  input wire logic [7:0] nv_startup_mode,
  input wire logic [15:0] nv_period_ticks,
  input wire logic [15:0] nv_ramp_time,
  input wire logic [31:0] nv_boot_duty,
  output logic nv_save,
  output logic [7:0] nv_startup_mode_out,
  output logic [15:0] nv_period_ticks_out,
  output logic [15:0] nv_ramp_time_out,
  output logic [31:0] nv_boot_duty_out,
  output logic [3:0] pwm_out,
  output logic sleep_ok
);
  import pwm_ramp_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    phase_t phase;
    logic [7:0] startup_mode;
    logic [31:0] duty_word;
    logic duty_written;
    logic [31:0] boot_duty;
    logic [15:0] period_ticks;
    logic [15:0] ramp_time;
    logic [31:0] cur_duty;
    logic [63:0] thr;
    logic [15:0] period_act;
    logic [15:0] cnt;
    logic [17:0] tick_acc;
    logic [31:0] step_cnt;
    logic [15:0] unit_cnt;
    logic [31:0] rdata;
    logic rvalid;
    logic save;
    logic [3:0] pwm;
  } state_t;

  state_t st_reg;
  state_t st_next;

  // Scaled high-time threshold in ticks for one duty byte
  function automatic logic [15:0] scale(input logic [7:0] d, input logic [15:0] p);
    logic [23:0] prod;
    prod = 24'(d) * 24'(p);
    return 16'(prod / 24'd255);
  endfunction

  // Move one byte a single step toward its target
  function automatic logic [7:0] step_toward(input logic [7:0] c, input logic [7:0] t);
    logic [7:0] r;
    r = c;
    if (c < t) begin
      r = c + 8'd1;
    end else if (c > t) begin
      r = c - 8'd1;
    end
    return r;
  endfunction

  logic [31:0] target;
  logic step_now;
  logic tick;
  logic wrap;
  logic [31:0] step_last;

  assign step_last = 32'(STEP_CYCLES - 1);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.save = 1'b0;
    st_next.rvalid = 1'b0;
    target = st_reg.duty_written ? st_reg.duty_word : st_reg.boot_duty;
    tick = 1'b0;
    wrap = 1'b0;
    step_now = 1'b0;

    unique case (st_reg.phase)
      PH_LOAD: begin
        // Restore retained settings once, after reset has released
        if (nv_valid) begin
          st_next.startup_mode = nv_startup_mode;
          st_next.period_ticks = nv_period_ticks;
          st_next.ramp_time = nv_ramp_time;
        end
        if (nv_valid && nv_startup_mode == MODE_KEEP_CURRENT) begin
          st_next.boot_duty = nv_boot_duty;
        end else if (nv_valid && nv_startup_mode == MODE_START_LOW) begin
          st_next.boot_duty = DUTY_ALL_LOW;
        end else begin
          st_next.boot_duty = DUTY_ALL_HIGH;
        end
        st_next.cur_duty = st_next.boot_duty;
        st_next.period_act = st_next.period_ticks;
        for (int i = 0; i < 4; i++) begin
          st_next.thr[i*16 +: 16] = scale(st_next.boot_duty[i*8 +: 8], st_next.period_ticks);
        end
        st_next.phase = PH_RUN;
      end
      PH_RUN: begin
        // Fractional tick generator: exact 0.25 us average from the system clock
        if (st_reg.tick_acc + CLK_PERIOD_PS_W >= TICK_PS_W) begin
          tick = 1'b1;
          st_next.tick_acc = st_reg.tick_acc + CLK_PERIOD_PS_W - TICK_PS_W;
        end else begin
          st_next.tick_acc = st_reg.tick_acc + CLK_PERIOD_PS_W;
        end
        if (tick) begin
          if (st_reg.cnt + 16'd1 >= st_reg.period_act || st_reg.cnt == 16'hffff) begin
            wrap = 1'b1;
            st_next.cnt = 16'h0000;
          end else begin
            st_next.cnt = st_reg.cnt + 16'd1;
          end
        end

        // Ramp stepping
        if (st_reg.ramp_time == 16'h0000) begin
          st_next.cur_duty = target;
          st_next.step_cnt = 32'h0;
          st_next.unit_cnt = 16'h0;
        end else if (st_reg.step_cnt >= step_last) begin
          st_next.step_cnt = 32'h0;
          if (st_reg.unit_cnt + 16'd1 >= st_reg.ramp_time) begin
            st_next.unit_cnt = 16'h0;
            step_now = 1'b1;
          end else begin
            st_next.unit_cnt = st_reg.unit_cnt + 16'd1;
          end
        end else begin
          st_next.step_cnt = st_reg.step_cnt + 32'd1;
        end
        if (step_now) begin
          for (int i = 0; i < 4; i++) begin
            st_next.cur_duty[i*8 +: 8] = step_toward(st_reg.cur_duty[i*8 +: 8], target[i*8 +: 8]);
          end
        end

        // New period and thresholds only at the boundary
        if (wrap) begin
          st_next.period_act = st_reg.period_ticks;
          for (int i = 0; i < 4; i++) begin
            st_next.thr[i*16 +: 16] = scale(st_reg.cur_duty[i*8 +: 8], st_reg.period_ticks);
          end
        end

        // Characteristic writes
        if (attr_wr) begin
          unique case (attr_handle)
            HANDLE_STARTUP_MODE: begin
              st_next.startup_mode = attr_wdata[7:0];
              st_next.save = 1'b1;
              if (attr_wdata[7:0] == MODE_KEEP_CURRENT) begin
                st_next.boot_duty = st_reg.cur_duty;
              end
            end
            HANDLE_DUTY_WORD: begin
              st_next.duty_word = attr_wdata;
              st_next.duty_written = 1'b1;
            end
            HANDLE_PERIOD_TICKS: begin
              st_next.period_ticks = attr_wdata[15:0];
              st_next.save = 1'b1;
            end
            HANDLE_RAMP_TIME: begin
              st_next.ramp_time = attr_wdata[15:0];
              st_next.save = 1'b1;
            end
            default: begin
            end
          endcase
        end

        // Characteristic reads, answered one cycle later
        if (attr_rd) begin
          st_next.rvalid = 1'b1;
          unique case (attr_handle)
            HANDLE_STARTUP_MODE: st_next.rdata = {24'h000000, st_reg.startup_mode};
            HANDLE_DUTY_WORD: st_next.rdata = st_reg.duty_word;
            HANDLE_PERIOD_TICKS: st_next.rdata = {16'h0000, st_reg.period_ticks};
            HANDLE_RAMP_TIME: st_next.rdata = {16'h0000, st_reg.ramp_time};
            default: st_next.rdata = 32'h00000000;
          endcase
        end
      end
    endcase

    // Channel outputs: channel one is the top byte, bit 3 of pwm
    for (int i = 0; i < 4; i++) begin
      st_next.pwm[i] = (st_next.cnt < st_next.thr[i*16 +: 16]);
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg <= '{
        phase: PH_LOAD,
        startup_mode: STARTUP_MODE_RESET,
        duty_word: DUTY_WORD_RESET,
        duty_written: 1'b0,
        boot_duty: DUTY_ALL_HIGH,
        period_ticks: PERIOD_TICKS_RESET,
        ramp_time: RAMP_TIME_RESET,
        cur_duty: DUTY_ALL_HIGH,
        thr: 64'h0,
        period_act: PERIOD_TICKS_RESET,
        cnt: 16'h0000,
        tick_acc: 18'h00000,
        step_cnt: 32'h0,
        unit_cnt: 16'h0000,
        rdata: 32'h00000000,
        rvalid: 1'b0,
        save: 1'b0,
        pwm: 4'h0
      };
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign attr_rdata = st_reg.rdata;
  assign attr_rvalid = st_reg.rvalid;
  assign nv_save = st_reg.save;
  assign nv_startup_mode_out = st_reg.startup_mode;
  assign nv_period_ticks_out = st_reg.period_ticks;
  assign nv_ramp_time_out = st_reg.ramp_time;
  assign nv_boot_duty_out = st_reg.boot_duty;
  assign pwm_out = st_reg.pwm;
  assign sleep_ok = (st_reg.startup_mode != MODE_KEEP_CURRENT)
    && (st_reg.duty_word == DUTY_ALL_HIGH);

endmodule

/* File: test/pwm_chk_asserts.sv */
`timescale 1ns/1ps
module pwm_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic attr_wr,
  input wire logic attr_rd,
  input wire logic [7:0] attr_handle,
  input wire logic [31:0] attr_wdata,
  input wire logic [31:0] attr_rdata,
  input wire logic attr_rvalid,
  input wire logic nv_save,
  input wire logic [7:0] nv_startup_mode_out,
  input wire logic [15:0] nv_period_ticks_out,
  input wire logic [15:0] nv_ramp_time_out,
  input wire logic sleep_ok
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_rv;
    !$past(rst) |-> attr_rvalid == $past(attr_rd);
  endproperty
  a_rv: assert property (p_rv) else $error("read answer out of step");
  property p_mode_save;
    attr_wr && attr_handle == 8'h4d && !$past(rst) |=> nv_save && nv_startup_mode_out == $past(attr_wdata[7:0]);
  endproperty
  a_mode_save: assert property (p_mode_save) else $error("mode not saved");
  property p_per_save;
    attr_wr && attr_handle == 8'h53 && !$past(rst) |=> nv_save && nv_period_ticks_out == $past(attr_wdata[15:0]);
  endproperty
  a_per_save: assert property (p_per_save) else $error("period not saved");
  property p_ramp_save;
    attr_wr && attr_handle == 8'h56 && !$past(rst) |=> nv_save && nv_ramp_time_out == $past(attr_wdata[15:0]);
  endproperty
  a_ramp_save: assert property (p_ramp_save) else $error("ramp time not saved");
  property p_mode2;
    attr_wr && attr_handle == 8'h4d && attr_wdata[7:0] == 8'h02 && !$past(rst) |=> !sleep_ok ##0 nv_save;
  endproperty
  a_mode2: assert property (p_mode2) else $error("mode two still sleeps");
  property p_sleep_mode;
    sleep_ok |-> nv_startup_mode_out != 8'h02;
  endproperty
  a_sleep_mode: assert property (p_sleep_mode) else $error("sleep in mode two");
  property p_wake;
    attr_wr && attr_handle == 8'h50 && attr_wdata != 32'hffffffff && !$past(rst) |=> !sleep_ok;
  endproperty
  a_wake: assert property (p_wake) else $error("sleep with duty on");
  property p_unmap;
    attr_rd && !(attr_handle inside {8'h4d, 8'h50, 8'h53, 8'h56}) && !$past(rst) |=> attr_rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_narrow;
    attr_rd && attr_handle == 8'h4d && !$past(rst) |=> attr_rdata[31:8] == 24'h0;
  endproperty
  a_narrow: assert property (p_narrow) else $error("mode read too wide");
  c_mode2: cover property (attr_wr && attr_handle == 8'h4d && attr_wdata[7:0] == 8'h02);
  c_rv: cover property (attr_rvalid);
  c_save: cover property (nv_save);
endmodule
bind quad_pwm_with_ramp pwm_chk u_pwm_chk (.sys_clk(sys_clk), .rst(rst), .attr_wr(attr_wr), .attr_rd(attr_rd),
  .attr_handle(attr_handle), .attr_wdata(attr_wdata), .attr_rdata(attr_rdata), .attr_rvalid(attr_rvalid),
  .nv_save(nv_save), .nv_startup_mode_out(nv_startup_mode_out), .nv_period_ticks_out(nv_period_ticks_out),
  .nv_ramp_time_out(nv_ramp_time_out), .sleep_ok(sleep_ok));

/* File: test/pwm_client.sv */
`timescale 1ns/1ps
// Remote client: one strobe per access, released lines show inverted data after a write, inverted handle after a read
module pwm_client (
  input wire logic sys_clk,
  output logic attr_wr,
  output logic attr_rd,
  output logic [7:0] attr_handle,
  output logic [31:0] attr_wdata,
  input wire logic [31:0] attr_rdata,
  input wire logic attr_rvalid
);
  initial begin
    attr_wr = 1'b0;
    attr_rd = 1'b0;
    attr_handle = 8'h00;
    attr_wdata = 32'h0;
  end
  task automatic wr(input logic [7:0] h, input logic [31:0] d);
    @(posedge sys_clk);
    attr_wr <= 1'b1;
    attr_handle <= h;
    attr_wdata <= d;
    @(posedge sys_clk);
    attr_wr <= 1'b0;
    attr_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] h, output logic [31:0] r, output logic ok);
    @(posedge sys_clk);
    attr_rd <= 1'b1;
    attr_handle <= h;
    @(posedge sys_clk);
    attr_rd <= 1'b0;
    attr_handle <= ~h;
    #1;
    r = attr_rdata;
    ok = attr_rvalid;
  endtask
endmodule

/* File: test/tb.sv */
`timescale 1ns/1ps
module tb;
  import pwm_ramp_pkg::*;
  logic sys_clk, rst, attr_wr, attr_rd, attr_rvalid, nv_valid, nv_save, sleep_ok;
  logic [7:0] attr_handle, nv_mode, mode_o;
  logic [15:0] nv_per, nv_ramp, per_o, ramp_o;
  logic [31:0] attr_wdata, attr_rdata, nv_duty, duty_o, d, v;
  logic [3:0] pwm_out;
  int err_count, n_tests, hi[4];
  int mt[3] = '{2, 0, 1};
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  quad_pwm_with_ramp #(.STEP_CYCLES(4)) u_quad_pwm_with_ramp (.sys_clk(sys_clk), .rst(rst), .attr_wr(attr_wr),
    .attr_rd(attr_rd), .attr_handle(attr_handle), .attr_wdata(attr_wdata), .attr_rdata(attr_rdata),
    .attr_rvalid(attr_rvalid), .nv_valid(nv_valid), .nv_startup_mode(nv_mode), .nv_period_ticks(nv_per),
    .nv_ramp_time(nv_ramp), .nv_boot_duty(nv_duty), .nv_save(nv_save), .nv_startup_mode_out(mode_o),
    .nv_period_ticks_out(per_o), .nv_ramp_time_out(ramp_o), .nv_boot_duty_out(duty_o), .pwm_out(pwm_out),
    .sleep_ok(sleep_ok));
  pwm_client u_pwm_client (.sys_clk(sys_clk), .attr_wr(attr_wr), .attr_rd(attr_rd), .attr_handle(attr_handle),
    .attr_wdata(attr_wdata), .attr_rdata(attr_rdata), .attr_rvalid(attr_rvalid));
  // Retained storage across power cycles
  always @(posedge sys_clk) begin
    if (nv_save === 1'b1) begin
      nv_mode <= mode_o;
      nv_per <= per_o;
      nv_ramp <= ramp_o;
      nv_duty <= duty_o;
    end
  end
  function automatic int exp_high(input logic [7:0] x);
    return (int'(x) * 500 / 255) * 125 / 4;
  endfunction
  // One byte after n single steps toward its target
  function automatic int ramp_byte(input int c, input int t, input int n);
    if (c < t) return (c + n < t) ? c + n : t;
    return (c - n > t) ? c - n : t;
  endfunction
  function automatic logic [31:0] exp_pwm(input int m);
    return m == 0 ? 32'h0 : m == 1 ? 32'hf : 32'ha;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_near(input int got, input int exp);
    n_tests++;
    if (got > exp + 2 || got < exp - 2) begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] h, input logic [31:0] e);
    logic [31:0] r;
    logic ok;
    u_pwm_client.rd(h, r, ok);
    chk(32'(ok), 32'h1);
    chk(r, e);
  endtask
  task automatic wrrd(input logic [7:0] h, input logic [31:0] e);
    u_pwm_client.wr(h, e);
    rdchk(h, e);
  endtask
  task automatic boot(input logic valid);
    @(posedge sys_clk);
    rst <= 1'b1;
    nv_valid <= valid;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge sys_clk);
    err_count++;
    print_verdict;
  end
  initial begin
    rst = 1'b1;
    nv_valid = 1'b0;
    {nv_mode, nv_per, nv_ramp, nv_duty} = '0;
    void'($urandom(20));
    boot(1'b0);
    chk(32'(sleep_ok), 32'h1);
    rdchk(HANDLE_STARTUP_MODE, 32'h01);
    rdchk(HANDLE_DUTY_WORD, 32'hffffffff);
    rdchk(HANDLE_PERIOD_TICKS, 32'h8235);
    rdchk(HANDLE_RAMP_TIME, 32'h0);
    rdchk(8'h00, 32'h0);
    $display("test factory done");
    wrrd(HANDLE_PERIOD_TICKS, 500 + $urandom % 65036);
    wrrd(HANDLE_RAMP_TIME, 32'($urandom) & 32'hffff);
    wrrd(HANDLE_RAMP_TIME, 32'h0);
    wrrd(HANDLE_PERIOD_TICKS, 500);
    // Restart so the short period is in force at once
    boot(1'b1);
    rdchk(HANDLE_PERIOD_TICKS, 32'd500);
    d = {8'hff, 8'h00, 16'($urandom)};
    wrrd(HANDLE_DUTY_WORD, d);
    chk(32'(sleep_ok), 32'h0);
    repeat (15800) @(posedge sys_clk);
    hi = '{0, 0, 0, 0};
    repeat (15625) begin
      @(posedge sys_clk);
      #1;
      for (int b = 0; b < 4; b++) hi[b] += (pwm_out[b] === 1'b1) ? 1 : (pwm_out[b] === 1'b0) ? 0 : 100000;
    end
    for (int b = 0; b < 4; b++) chk_near(hi[b], exp_high(d[8*b +: 8]));
    $display("test duty done");
    // One ramp unit: a step every 4 clocks, about 100 steps before the snapshot
    v = 32'hff00ff00;
    wrrd(HANDLE_RAMP_TIME, 32'h1);
    wrrd(HANDLE_DUTY_WORD, v);
    repeat (397) @(posedge sys_clk);
    u_pwm_client.wr(HANDLE_STARTUP_MODE, 32'h2);
    #1;
    for (int b = 0; b < 4; b++) begin
      chk_near(int'(duty_o[8*b +: 8]), ramp_byte(d[8*b +: 8], v[8*b +: 8], 100));
    end
    wrrd(HANDLE_RAMP_TIME, 32'h0);
    $display("test ramp done");
    for (int i = 0; i < 3; i++) begin
      wrrd(HANDLE_STARTUP_MODE, mt[i]);
      boot(1'b1);
      chk(32'(sleep_ok), 32'(mt[i] != 2));
      rdchk(HANDLE_STARTUP_MODE, mt[i]);
      rdchk(HANDLE_PERIOD_TICKS, 500);
      rdchk(HANDLE_DUTY_WORD, 32'hffffffff);
      repeat (15800) @(posedge sys_clk);
      chk(32'(pwm_out), exp_pwm(mt[i]));
      $display("test mode %0d done", mt[i]);
    end
    print_verdict;
  end
endmodule
